/* File: rtl/spm_defines.svh */
`ifndef SPM_DEFINES_SVH
`define SPM_DEFINES_SVH
// register offsets on the plain port
`define SPM_OFS_C1 3'h0
`define SPM_OFS_C2 3'h1
`define SPM_OFS_BR 3'h2
`define SPM_OFS_ST 3'h3
`define SPM_OFS_MH 3'h4
`define SPM_OFS_ML 3'h5
`define SPM_OFS_DH 3'h6
`define SPM_OFS_DL 3'h7
// control_one bit positions
`define SPM_C1_RXIE 7
`define SPM_C1_ON 6
`define SPM_C1_TXIE 5
`define SPM_C1_MASTER_SELECT_BIT 4
`define SPM_C1_CLOCK_POLARITY_BIT 3
`define SPM_C1_CLOCK_PHASE_BIT 2
`define SPM_C1_SELECT_OUTPUT_ENABLE 1
`define SPM_C1_LSBF 0
// control_two bit positions and implemented-bit mask
`define SPM_C2_MIE 7
`define SPM_C2_WIDE 6
`define SPM_C2_FEN 4
`define SPM_C2_DIR 3
`define SPM_C2_SWAI 1
`define SPM_C2_SPM 0
`define SPM_C2_MASK 8'hDB
// bit_rate fields and mask
`define SPM_BR_MASK 8'h77
`define SPM_BR_PRE 6:4
`define SPM_BR_RATE 2:0
// status bit positions
`define SPM_ST_RXF 7
`define SPM_ST_MTCH 6
`define SPM_ST_TXE 5
`define SPM_ST_MODE_FAULT_FLAG 4
// reset values
`define SPM_C1_RST 8'h00
`define SPM_C2_RST 8'h00
`define SPM_BR_RST 8'h00
`define SPM_MT_RST 8'h00
`define SPM_DATA_RST 16'h0000
// last edge index of a word (two edges per bit)
`define SPM_LAST_WIDE 5'h1F
`define SPM_LAST_NARROW 5'h0F
// divider width and unit step
`define SPM_DIV_ONE 10'h001
`define SPM_PRE_PAD 7'h00
`endif

/* File: rtl/spm_pkg.sv */
package spm_pkg;
  // transfer engine phase
  typedef enum logic [1:0] {
    SPM_IDLE = 2'b00,
    SPM_MXFER = 2'b01,
    SPM_SXFER = 2'b10
  } spm_mode_t;

  // whole state of the main block
  typedef struct packed {
    logic [7:0] c1;
    logic [7:0] c2;
    logic [7:0] br;
    logic [7:0] mh;
    logic [7:0] ml;
    logic [15:0] txb;
    logic [15:0] rxb;
    logic [15:0] sh;
    logic [15:0] pend;
    logic [7:0] rdata;
    logic rxf;
    logic txe;
    logic mtch;
    logic mode_fault_flag;
    logic rx_arm;
    logic tx_arm;
    logic mode_fault_flag_arm;
    logic pend_v;
    logic straddle;
    logic src_buf;
    logic quiet;
    logic loaded;
    spm_mode_t mode;
    logic [4:0] ecnt;
    logic rbit;
    logic sclk_prev;
    logic sclk_o;
    logic sclk_oen;
    logic mosi_o;
    logic mosi_oen;
    logic miso_o;
    logic miso_oen;
    logic ss_o;
    logic ss_oen;
    logic irq;
  } spm_state_t;

  // state of the bit-rate divider
  typedef struct packed {
    logic [9:0] cnt;
    logic tick;
  } spm_baud_t;
endpackage

/* File: rtl/spm_baud.sv */
`timescale 1ns/1ps
`include "spm_defines.svh"
// half-bit enable pulse for a master transfer
module spm_baud
  import spm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [2:0] prescale,
  input wire logic [2:0] rate,
  output logic tick
);
  spm_baud_t s_ff; // registered state
  spm_baud_t nxt_s; // next state
  logic [9:0] term; // last count of a half period

  // half period is (prescale+1)*2^rate, so a full bit is the divisor
  assign term = (({`SPM_PRE_PAD, prescale} + `SPM_DIV_ONE) << rate)
                - `SPM_DIV_ONE;

  // counter only runs during a master transfer to save power
  always_comb begin
    nxt_s = s_ff;
    nxt_s.tick = 1'b0;
    if (!run) begin
      nxt_s.cnt = '0;
    end else if (s_ff.cnt >= term) begin
      nxt_s.cnt = '0;
      nxt_s.tick = 1'b1;
    end else begin
      nxt_s.cnt = s_ff.cnt + `SPM_DIV_ONE;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign tick = s_ff.tick;
endmodule

/* File: rtl/spm_top.sv */
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ps
`include "spm_defines.svh"
// What this block does
// - module off: core idle, registers accessible
// - stop-in-wait: master freezes, resumes after wait
// - slave keeps shifting while master clocks
// - slave in wait keeps same transmit source
// - low power: slave result deferred until exit
// - deferred result only if transfer straddled
// - light stop freezes master, slave stays synced
// - deep stop resets all registers
// - data reads return zero after reset
// - interrupt only while module on
// - each flag gated by its enable
// - mode fault aborts, clears master, holds irq
// - receive full after whole word copied
// - unserviced receive full discards later words
// - transmit empty after word moved to shifter
// - match flag compares narrow or wide word
// - match high ignored narrow; high byte wide
// - control one bit layout
// - control two bit layout
// - bit rate fields, reserved bits zero
// - status bit layout
// - status read then control write clears fault
// - divisor (prescale+1) times 2^(rate+1)
module spm_top
  import spm_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic cpu_wait,
  input wire logic stop_light,
  input wire logic stop_deep,
  input wire logic serial_clock_in,
  output logic serial_clock_out,
  output logic serial_clock_oe_n,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe_n,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe_n,
  input wire logic select_n_in,
  output logic select_n_out,
  output logic select_n_oe_n,
  output logic irq_out
);
  logic [1:0] rst_sync_ff; // reset release chain
  logic rst_n; // synchronised reset
  spm_state_t s_ff; // registered state
  spm_state_t nxt_s; // next state
  logic tick; // half-bit pulse from divider
  logic on, master, wide, lsb, clock_phase_bit, single, quiet, din, run;
  logic [4:0] last_e; // last edge index of this word size
  logic [15:0] word; // shifter after the current edge

  // shift one bit in, keeping unused high byte clear in narrow mode
  function automatic logic [15:0] shift_in(input logic [15:0] v,
      input logic b, input logic w, input logic l);
    logic [15:0] r;
    r = v;
    if (l) begin
      r = w ? {b, v[15:1]} : {8'h00, b, v[7:1]};
    end else begin
      r = w ? {v[14:0], b} : {8'h00, v[6:0], b};
    end
    return r;
  endfunction

  // bit presented on the data output
  function automatic logic out_bit(input logic [15:0] v, input logic w,
      input logic l);
    return l ? v[0] : (w ? v[15] : v[7]);
  endfunction

  // match test on a delivered word
  function automatic logic is_match(input logic [15:0] v,
      input logic [7:0] hi, input logic [7:0] lo, input logic w);
    return w ? (v == {hi, lo}) : (v[7:0] == lo);
  endfunction

  // reset picture of the whole block
  function automatic spm_state_t rst_state();
    spm_state_t r;
    r = '0;
    r.c1 = `SPM_C1_RST;
    r.c2 = `SPM_C2_RST;
    r.br = `SPM_BR_RST;
    r.mh = `SPM_MT_RST;
    r.ml = `SPM_MT_RST;
    r.rxb = `SPM_DATA_RST;
    r.txe = 1'b1;
    r.mode = SPM_IDLE;
    r.sclk_oen = 1'b1;
    r.mosi_oen = 1'b1;
    r.miso_oen = 1'b1;
    r.ss_o = 1'b1;
    r.ss_oen = 1'b1;
    return r;
  endfunction

  // reset is asserted at once but released on the clock
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // decoded control bits
  assign on = s_ff.c1[`SPM_C1_ON];
  assign master = s_ff.c1[`SPM_C1_MASTER_SELECT_BIT];
  assign clock_phase_bit = s_ff.c1[`SPM_C1_CLOCK_PHASE_BIT];
  assign lsb = s_ff.c1[`SPM_C1_LSBF];
  assign wide = s_ff.c2[`SPM_C2_WIDE];
  assign single = s_ff.c2[`SPM_C2_SPM];
  assign last_e = wide ? `SPM_LAST_WIDE : `SPM_LAST_NARROW;
  // light stop ignores stop-in-wait; wait only with it set
  assign quiet = (cpu_wait & s_ff.c2[`SPM_C2_SWAI])
                 | stop_light;
  // in single-pin mode one data pin carries both directions
  assign din = single ? (master ? mosi_in : miso_in)
                      : (master ? miso_in : mosi_in);
  assign run = on & (s_ff.mode == SPM_MXFER) & ~quiet;
  // a shift edge takes the bit sampled before it, since the far side may
  // already show the next bit; only the closing phase-one edge takes the pin
  assign word = shift_in(s_ff.sh, (clock_phase_bit & s_ff.ecnt[0]) ? din : s_ff.rbit,
                         wide, lsb);

  // master bit clock divider
  spm_baud u_baud (
    .clk(clk),
    .rst_n(rst_n),
    .run(run),
    .prescale(s_ff.br[`SPM_BR_PRE]),
    .rate(s_ff.br[`SPM_BR_RATE]),
    .tick(tick)
  );

  // registers, flags and the transfer engine
  always_comb begin
    logic edge_go, samp, done, reload;
    nxt_s = s_ff;
    edge_go = 1'b0;
    samp = 1'b0;
    done = 1'b0;
    reload = 1'b0;
    nxt_s.rdata = 8'h00;
    nxt_s.sclk_prev = serial_clock_in;
    nxt_s.quiet = quiet;

    // register writes; clears come first so a set below wins
    if (reg_wr) begin
      case (reg_addr)
        `SPM_OFS_C1: begin
          nxt_s.c1 = reg_wdata;
          if (s_ff.mode_fault_flag_arm) begin
            nxt_s.mode_fault_flag = 1'b0;
            nxt_s.mode_fault_flag_arm = 1'b0;
          end
        end
        `SPM_OFS_C2: nxt_s.c2 = reg_wdata & `SPM_C2_MASK;
        `SPM_OFS_BR: nxt_s.br = reg_wdata & `SPM_BR_MASK;
        `SPM_OFS_ST: begin
          if (reg_wdata[`SPM_ST_MTCH]) begin
            nxt_s.mtch = 1'b0; // write one to clear match
          end
        end
        `SPM_OFS_MH: begin
          if (wide) begin
            nxt_s.mh = reg_wdata;
          end
        end
        `SPM_OFS_ML: nxt_s.ml = reg_wdata;
        `SPM_OFS_DH: nxt_s.txb[15:8] = reg_wdata;
        `SPM_OFS_DL: begin
          nxt_s.txb[7:0] = reg_wdata;
          if (s_ff.tx_arm) begin
            nxt_s.txe = 1'b0;
            nxt_s.tx_arm = 1'b0;
          end
        end
        default: nxt_s.ml = s_ff.ml;
      endcase
    end

    // register reads; data stands one cycle later only
    if (reg_rd) begin
      case (reg_addr)
        `SPM_OFS_C1: nxt_s.rdata = s_ff.c1;
        `SPM_OFS_C2: nxt_s.rdata = s_ff.c2;
        `SPM_OFS_BR: nxt_s.rdata = s_ff.br;
        `SPM_OFS_ST: begin
          nxt_s.rdata = {s_ff.rxf, s_ff.mtch, s_ff.txe, s_ff.mode_fault_flag,
                         4'h0};
          nxt_s.rx_arm = s_ff.rxf;
          nxt_s.tx_arm = s_ff.txe;
          nxt_s.mode_fault_flag_arm = s_ff.mode_fault_flag;
        end
        `SPM_OFS_MH: nxt_s.rdata = s_ff.mh;
        `SPM_OFS_ML: nxt_s.rdata = s_ff.ml;
        `SPM_OFS_DH: nxt_s.rdata = s_ff.rxb[15:8];
        `SPM_OFS_DL: begin
          nxt_s.rdata = s_ff.rxb[7:0];
          if (s_ff.rx_arm) begin
            nxt_s.rxf = 1'b0;
            nxt_s.rx_arm = 1'b0;
          end
        end
        default: nxt_s.rdata = 8'h00;
      endcase
    end

    // low-power entry: note mid-transfer state and transmit source
    if (quiet && !s_ff.quiet) begin
      nxt_s.straddle = (s_ff.mode == SPM_SXFER) &&
                       (s_ff.ecnt != 5'h00);
      nxt_s.src_buf = s_ff.loaded;
    end
    // low-power exit: hand over a deferred word
    if (!quiet && s_ff.quiet) begin
      nxt_s.straddle = 1'b0;
      if (s_ff.pend_v) begin
        nxt_s.pend_v = 1'b0;
        if (!nxt_s.rxf) begin
          nxt_s.rxb = s_ff.pend;
          nxt_s.rxf = 1'b1;
          if (is_match(s_ff.pend, s_ff.mh, s_ff.ml, wide)) begin
            nxt_s.mtch = 1'b1;
          end
        end
      end
    end

    // edge detection: divider for a master, pin for a slave
    case (s_ff.mode)
      SPM_MXFER: edge_go = tick;
      SPM_SXFER: edge_go = serial_clock_in != s_ff.sclk_prev;
      default: edge_go = 1'b0;
    endcase
    samp = clock_phase_bit ? s_ff.ecnt[0] : ~s_ff.ecnt[0];

    // start of a transfer
    if (s_ff.mode == SPM_IDLE && on) begin
      if (master && !s_ff.txe && !s_ff.mode_fault_flag && !quiet) begin
        nxt_s.mode = SPM_MXFER;
        nxt_s.ecnt = 5'h00;
        nxt_s.sh = s_ff.txb;
        nxt_s.txe = 1'b1;
        nxt_s.loaded = 1'b1;
      end else if (!master && !select_n_in) begin
        nxt_s.mode = SPM_SXFER;
        nxt_s.ecnt = 5'h00;
        reload = 1'b1;
      end
    end else if (s_ff.mode == SPM_SXFER && select_n_in) begin
      nxt_s.mode = SPM_IDLE; // deselect drops a partial word
      nxt_s.ecnt = 5'h00;
    end else if (edge_go) begin
      nxt_s.ecnt = s_ff.ecnt + 5'h01;
      if (s_ff.mode == SPM_MXFER) begin
        nxt_s.sclk_o = ~s_ff.sclk_o;
      end
      if (samp) begin
        nxt_s.rbit = din;
        done = clock_phase_bit && (s_ff.ecnt == last_e);
      end else begin
        if (!clock_phase_bit || s_ff.ecnt != 5'h00) begin
          nxt_s.sh = word;
        end
        done = !clock_phase_bit && (s_ff.ecnt == last_e);
      end
    end

    // end of a word: deliver or defer, then pick next source
    if (done) begin
      nxt_s.ecnt = 5'h00;
      reload = 1'b1;
      if (s_ff.mode == SPM_SXFER && quiet) begin
        if (s_ff.straddle) begin
          nxt_s.pend = word;
          nxt_s.pend_v = 1'b1;
        end
        nxt_s.straddle = 1'b0;
      end else if (!nxt_s.rxf) begin
        nxt_s.rxb = word;
        nxt_s.rxf = 1'b1;
        if (is_match(word, s_ff.mh, s_ff.ml, wide)) begin
          nxt_s.mtch = 1'b1;
        end
      end // a full buffer drops the new word
      if (s_ff.mode == SPM_MXFER) begin
        nxt_s.mode = SPM_IDLE;
        nxt_s.sclk_o = s_ff.c1[`SPM_C1_CLOCK_POLARITY_BIT];
        reload = 1'b0; // master restarts through the idle path
      end else begin
        nxt_s.sh = word; // echo received word when nothing new
      end
    end

    // slave load: frozen source in low power, else buffer if filled
    if (reload) begin
      if (quiet) begin
        if (s_ff.src_buf) begin
          nxt_s.sh = s_ff.txb;
        end
      end else if (!nxt_s.txe) begin
        nxt_s.sh = s_ff.txb;
        nxt_s.txe = 1'b1;
        nxt_s.loaded = 1'b1;
      end else begin
        nxt_s.loaded = 1'b0;
      end
    end

    // mode fault: another master pulled select low
    if (on && master && nxt_s.c1[`SPM_C1_MASTER_SELECT_BIT] &&
        s_ff.c2[`SPM_C2_FEN] && !s_ff.c1[`SPM_C1_SELECT_OUTPUT_ENABLE] &&
        !select_n_in) begin
      nxt_s.mode_fault_flag = 1'b1;
      nxt_s.c1[`SPM_C1_MASTER_SELECT_BIT] = 1'b0;
      nxt_s.mode = SPM_IDLE;
      nxt_s.ecnt = 5'h00;
    end

    // module off: core idle but registers keep working
    if (!nxt_s.c1[`SPM_C1_ON]) begin
      nxt_s.mode = SPM_IDLE;
      nxt_s.ecnt = 5'h00;
    end
    if (nxt_s.mode == SPM_IDLE) begin
      nxt_s.sclk_o = nxt_s.c1[`SPM_C1_CLOCK_POLARITY_BIT];
    end

    // pin drive; fault keeps every output released
    begin
      logic m_drv, s_drv, pdir;
      m_drv = nxt_s.c1[`SPM_C1_ON] & nxt_s.c1[`SPM_C1_MASTER_SELECT_BIT] & ~nxt_s.mode_fault_flag;
      s_drv = nxt_s.c1[`SPM_C1_ON] & ~nxt_s.c1[`SPM_C1_MASTER_SELECT_BIT] &
              ~nxt_s.mode_fault_flag & ~select_n_in;
      pdir = ~nxt_s.c2[`SPM_C2_SPM] | nxt_s.c2[`SPM_C2_DIR];
      nxt_s.sclk_oen = ~m_drv;
      nxt_s.mosi_oen = ~(m_drv & pdir);
      nxt_s.miso_oen = ~(s_drv & pdir);
      nxt_s.mosi_o = out_bit(nxt_s.sh, nxt_s.c2[`SPM_C2_WIDE],
                             nxt_s.c1[`SPM_C1_LSBF]);
      nxt_s.miso_o = nxt_s.mosi_o;
      nxt_s.ss_oen = ~(m_drv & nxt_s.c1[`SPM_C1_SELECT_OUTPUT_ENABLE] &
                       nxt_s.c2[`SPM_C2_FEN]);
      nxt_s.ss_o = nxt_s.mode != SPM_MXFER;
    end

    // one shared request, only while the module is on
    nxt_s.irq = nxt_s.c1[`SPM_C1_ON] & (
      (nxt_s.c1[`SPM_C1_RXIE] & (nxt_s.rxf | nxt_s.mode_fault_flag)) |
      (nxt_s.c1[`SPM_C1_TXIE] & nxt_s.txe) |
      (nxt_s.c2[`SPM_C2_MIE] & nxt_s.mtch));

    // deep stop wipes everything back to reset values
    if (stop_deep) begin
      nxt_s = rst_state();
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= rst_state();
    end else begin
      s_ff <= nxt_s;
    end
  end

  // every output comes straight from the state register
  assign reg_rdata = s_ff.rdata;
  assign serial_clock_out = s_ff.sclk_o;
  assign serial_clock_oe_n = s_ff.sclk_oen;
  assign mosi_out = s_ff.mosi_o;
  assign mosi_oe_n = s_ff.mosi_oen;
  assign miso_out = s_ff.miso_o;
  assign miso_oe_n = s_ff.miso_oen;
  assign select_n_out = s_ff.ss_o;
  assign select_n_oe_n = s_ff.ss_oen;
  assign irq_out = s_ff.irq;
endmodule

/* File: tb/spm_top_sva.sv */
`timescale 1ns/1ps
`include "spm_defines.svh"
// port-level checks of the serial block, register shadows kept from writes
module spm_top_sva
  import spm_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic cpu_wait,
  input wire logic stop_light,
  input wire logic stop_deep,
  input wire logic serial_clock_out,
  input wire logic serial_clock_oe_n,
  input wire logic select_n_out,
  input wire logic irq_out
);
  logic [7:0] c1_ff; // shadow of control one (hardware clears not seen)
  logic [7:0] c2_ff; // shadow of control two
  logic [7:0] br_ff; // shadow of bit rate
  logic [10:0] gap_ff; // cycles since the clock pin last moved
  logic seen_ff; // an edge already seen in this running frame
  logic quiet; // divider frozen by wait or light stop
  logic en_any; // any interrupt enable set
  logic [10:0] half; // expected half period in bus cycles
  assign quiet = stop_light | (cpu_wait & c2_ff[`SPM_C2_SWAI]);
  assign en_any = c1_ff[`SPM_C1_RXIE] | c1_ff[`SPM_C1_TXIE] | c2_ff[7];
  assign half = ({8'h00, br_ff[6:4]} + 11'h001) << br_ff[2:0];
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // shadows and edge spacing; a frozen or ended frame restarts the spacing
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {c1_ff, c2_ff, br_ff} <= 24'h000000;
      gap_ff <= 11'h000;
      seen_ff <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `SPM_OFS_C1)
        c1_ff <= reg_wdata;
      if (reg_wr && reg_addr == `SPM_OFS_C2)
        c2_ff <= reg_wdata;
      if (reg_wr && reg_addr == `SPM_OFS_BR)
        br_ff <= reg_wdata;
      if (stop_deep)
        {c1_ff, c2_ff, br_ff} <= 24'h000000;
      gap_ff <= $changed(serial_clock_out) ? 11'h001 : gap_ff + 11'h001;
      seen_ff <= (seen_ff | $changed(serial_clock_out)) & ~select_n_out
        & ~quiet & ~stop_deep;
    end
  end
  a_rd_slot_only: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("stray read data");
  a_c2_reserved: assert property (
    reg_rd && reg_addr == `SPM_OFS_C2 |=> (reg_rdata & ~`SPM_C2_MASK) == 8'h00)
    else $error("control two reserved bits set");
  a_br_reserved: assert property (
    reg_rd && reg_addr == `SPM_OFS_BR |=> (reg_rdata & ~`SPM_BR_MASK) == 8'h00)
    else $error("bit rate reserved bits set");
  a_status_low: assert property (
    reg_rd && reg_addr == `SPM_OFS_ST |=> reg_rdata[3:0] == 4'h0)
    else $error("status low nibble set");
  a_irq_needs_on: assert property (
    irq_out |-> c1_ff[`SPM_C1_ON] || $past(c1_ff[`SPM_C1_ON]))
    else $error("interrupt while module off");
  a_irq_masked: assert property (
    irq_out |-> en_any || $past(en_any)) else $error("unmasked interrupt");
  a_wait_freeze: assert property (
    (cpu_wait && c2_ff[`SPM_C2_SWAI]) [*4] |-> $stable(serial_clock_out))
    else $error("clock moved in wait");
  a_light_freeze: assert property (
    stop_light [*4] |-> $stable(serial_clock_out))
    else $error("clock moved in light stop");
  a_deep_reset: assert property (
    stop_deep [*2] |-> !irq_out && serial_clock_oe_n && select_n_out)
    else $error("deep stop left state");
  a_off_no_drive: assert property (
    !c1_ff[`SPM_C1_ON] [*2] |-> serial_clock_oe_n)
    else $error("clock driven while off");
  a_clock_rate: assert property (
    $changed(serial_clock_out) && seen_ff |-> gap_ff == half)
    else $error("half bit period wrong");
endmodule

bind spm_top spm_top_sva i_sva (
  .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .cpu_wait(cpu_wait), .stop_light(stop_light), .stop_deep(stop_deep),
  .serial_clock_out(serial_clock_out), .serial_clock_oe_n(serial_clock_oe_n),
  .select_n_out(select_n_out), .irq_out(irq_out)
);

/* File: tb/spm_slave_model.sv */
`timescale 1ns/1ps
// far-side slave: drives on the leading clock edge, samples on the trailing
module spm_slave_model
  import spm_pkg::*;
(
  input wire logic clk,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic start,
  input wire logic wide,
  input wire logic [15:0] tx_word,
  output logic miso,
  output logic [15:0] rx_word,
  output logic busy
);
  logic bit_v = 1'b0; // bit on the wire inside a frame
  logic pat_ff = 1'b0; // released line, so a stale bit never reads as data
  initial busy = 1'b0;
  assign miso = busy ? bit_v : pat_ff;
  // outside frames the line changes every cycle
  always @(posedge clk)
    pat_ff <= ~pat_ff;
  // one frame per start pulse, msb first
  always begin
    @(posedge start);
    busy = 1'b1;
    rx_word = 16'h0000;
    for (int i = (wide ? 15 : 7); i >= 0; i--) begin
      @(posedge sclk);
      bit_v = tx_word[i];
      @(negedge sclk);
      rx_word = {rx_word[14:0], mosi};
    end
    busy = 1'b0;
  end
endmodule

/* File: tb/spm_top_tb.sv */
`timescale 1ns/1ps
`include "spm_defines.svh"
// register rows, master transfers, power modes and mode fault
module spm_top_tb
  import spm_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic cpu_wait = 1'b0;
  logic stop_light = 1'b0;
  logic stop_deep = 1'b0;
  logic select_n_in = 1'b1; // pulled up while nobody selects us
  logic start = 1'b0;
  logic wide = 1'b0;
  logic [15:0] mdl_tx = 16'h0000;
  logic sclk_in = 1'b0; // far master clock in the slave test
  logic mosi_drv = 1'b0; // far master data in the slave test
  logic [7:0] s_byte = 8'hA6; // word the far master sends
  logic [7:0] reg_rdata, v;
  logic serial_clock_out, mosi_out, miso_in, irq_out, busy, held;
  logic [15:0] mdl_rx;
  int n_mismatch = 0;
  int num_checks = 0;
  int cycles = 0;
  // rows: offset, written value, value read back
  logic [18:0] rows [0:8] = '{{`SPM_OFS_MH, 8'h5A, 8'h00},
    {`SPM_OFS_ML, 8'hA5, 8'hA5}, {`SPM_OFS_C2, 8'hFF, 8'hDB},
    {`SPM_OFS_BR, 8'hFF, 8'h77}, {`SPM_OFS_MH, 8'h5A, 8'h5A},
    {`SPM_OFS_C1, 8'hAD, 8'hAD}, {`SPM_OFS_C2, 8'h00, 8'h00},
    {`SPM_OFS_BR, 8'h00, 8'h00}, {`SPM_OFS_C1, 8'h00, 8'h00}};

  always #50 clk = ~clk;

  // slave-side clock and data in are driven by hand in the slave test
  spm_top i_dut (
    .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cpu_wait(cpu_wait), .stop_light(stop_light), .stop_deep(stop_deep),
    .serial_clock_in(sclk_in), .serial_clock_out(serial_clock_out),
    .serial_clock_oe_n(), .mosi_in(mosi_drv), .mosi_out(mosi_out),
    .mosi_oe_n(),
    .miso_in(miso_in), .miso_out(), .miso_oe_n(), .select_n_in(select_n_in),
    .select_n_out(), .select_n_oe_n(), .irq_out(irq_out)
  );
  spm_slave_model i_slave (
    .clk(clk), .sclk(serial_clock_out), .mosi(mosi_out), .start(start),
    .wide(wide), .tx_word(mdl_tx), .miso(miso_in), .rx_word(mdl_rx),
    .busy(busy)
  );

  task automatic results();
    if (n_mismatch == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    num_checks++;
    if (seen !== want) begin
      n_mismatch++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  // a gap cycle before each strobe keeps one driver assignment per step
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic do_reset();
    arst_n <= 1'b0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  // arm the slave, then status read and data write start the master
  task automatic xfer(input logic w, input logic [15:0] d,
                      input logic [15:0] m);
    wide <= w;
    mdl_tx <= m;
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    rd(`SPM_OFS_ST, v);
    chk(v[5], 1'b1);
    if (w)
      wr(`SPM_OFS_DH, d[15:8]);
    wr(`SPM_OFS_DL, d[7:0]);
    for (int k = 0; k < 1000 && busy === 1'b1; k++)
      @(posedge clk);
    chk(busy, 1'b0);
    idle(4);
  endtask

  // hang guard, well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      $display("BAD %0t timeout", $time);
      results();
    end
  end

  initial begin
    do_reset();
    foreach (rows[i]) begin
      wr(rows[i][18:16], rows[i][15:8]);
      rd(rows[i][18:16], v);
      chk(v, rows[i][7:0]);
    end
    @(posedge clk);
    do_reset();
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0], v);
      chk(v, a == 3 ? 8'h20 : 8'h00);
    end
    wr(`SPM_OFS_C1, 8'h20);
    idle(2);
    chk(irq_out, 1'b0);
    wr(`SPM_OFS_C1, 8'h60);
    idle(2);
    chk(irq_out, 1'b1);
    wr(`SPM_OFS_C1, 8'h54);
    idle(2);
    chk(irq_out, 1'b0);
    wr(`SPM_OFS_C2, 8'h80);
    wr(`SPM_OFS_BR, 8'h00);
    wr(`SPM_OFS_ML, 8'hC3);
    xfer(1'b0, 16'h003C, 16'h00C3);
    rd(`SPM_OFS_ST, v);
    chk(v, 8'hE0);
    chk(irq_out, 1'b1);
    chk(mdl_rx, 16'h003C);
    wr(`SPM_OFS_ML, 8'h00);
    wr(`SPM_OFS_ST, 8'h40);
    idle(2);
    chk(irq_out, 1'b0);
    // second word lands while receive full is still unserviced
    xfer(1'b0, 16'h0011, 16'h0077);
    rd(`SPM_OFS_ST, v);
    rd(`SPM_OFS_DL, v);
    chk(v, 8'hC3);
    chk(mdl_rx, 16'h0011);
    rd(`SPM_OFS_ST, v);
    chk(v, 8'h20);
    wr(`SPM_OFS_C2, 8'hC2);
    wr(`SPM_OFS_BR, 8'h11);
    wr(`SPM_OFS_MH, 8'h12);
    wr(`SPM_OFS_ML, 8'h34);
    // wide word frozen first by wait, then by light stop, mid-frame
    fork
      xfer(1'b1, 16'hABCD, 16'h1234);
      begin
        repeat (40) @(posedge clk);
        cpu_wait <= 1'b1;
        idle(4);
        held = serial_clock_out;
        idle(20);
        chk(serial_clock_out, held);
        @(posedge clk);
        cpu_wait <= 1'b0;
        repeat (20) @(posedge clk);
        stop_light <= 1'b1;
        idle(4);
        held = serial_clock_out;
        idle(20);
        chk(serial_clock_out, held);
        @(posedge clk);
        stop_light <= 1'b0;
      end
    join
    rd(`SPM_OFS_ST, v);
    chk(v, 8'hE0);
    rd(`SPM_OFS_DH, v);
    chk(v, 8'h12);
    rd(`SPM_OFS_DL, v);
    chk(v, 8'h34);
    chk(mdl_rx, 16'hABCD);
    @(posedge clk);
    stop_deep <= 1'b1;
    repeat (3) @(posedge clk);
    stop_deep <= 1'b0;
    rd(`SPM_OFS_C2, v);
    chk(v, 8'h00);
    chk(irq_out, 1'b0);
    // another master pulls select low while we are master
    wr(`SPM_OFS_C1, 8'hD0);
    wr(`SPM_OFS_C2, 8'h10);
    select_n_in <= 1'b0;
    repeat (3) @(posedge clk);
    select_n_in <= 1'b1;
    idle(3);
    chk(irq_out, 1'b1);
    rd(`SPM_OFS_ST, v);
    chk(v, 8'h30);
    rd(`SPM_OFS_C1, v);
    chk(v, 8'hC0);
    wr(`SPM_OFS_C1, 8'h40);
    idle(2);
    chk(irq_out, 1'b0);
    rd(`SPM_OFS_ST, v);
    chk(v, 8'h20);
    // far master clocks a word in phase one; wait rises mid-frame
    wr(`SPM_OFS_C1, 8'h44);
    wr(`SPM_OFS_C2, 8'h02);
    select_n_in <= 1'b0;
    for (int b = 7; b >= 0; b--) begin
      if (b == 4)
        cpu_wait <= 1'b1;
      repeat (3) @(posedge clk);
      sclk_in <= 1'b1;
      mosi_drv <= s_byte[b];
      repeat (3) @(posedge clk);
      sclk_in <= 1'b0;
    end
    rd(`SPM_OFS_ST, v);
    chk(v, 8'h20);
    @(posedge clk);
    cpu_wait <= 1'b0;
    rd(`SPM_OFS_ST, v);
    chk(v, 8'hA0);
    rd(`SPM_OFS_DL, v);
    chk(v, 8'hA6);
    results();
  end
endmodule
